// file: dfrla_engine.v
// Purpose: Transfer engine of one channel: fly-by and multi-cycle transfers.
// Assumes: The bus controller splits each request by region width.
// Notes: Bytes pass through a buffer so byte, short and word lengths pack freely.
// Behaviour
// - Source-synced fly-by: store with source acknowledged.
// - Data bus drivers stay off during fly-by.
// - Destination-synced fly-by: acknowledged load, data discarded.
// - Fly-by never addresses on-chip data RAM.
// - Block mode starts by command, ignores requests.
// - Bus request size follows configured length.
// - One request per demand; acknowledge spans it.
// - Narrower requests until address and count align.
// - Pack and unpack byte, short, word lengths.
// - Quad needs quad on both sides.
// - Byte to word: four loads, one store.
// - Incrementing any alignment; quad always quad-aligned.
// - Lengths set per side when channel starts.
// - Fly-by is one request, nothing buffered.
`timescale 1ns/100ps
`include "dfrla_map.vh"

module dfrla_engine #(
  parameter INT_RAM_TOP = `DFRLA_INT_RAM_TOP,
  parameter FIFO_DEPTH = `DFRLA_FIFO_DEPTH
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [1:0] cfgSrcLen,
  input wire [1:0] cfgDstLen,
  input wire cfgFlyBy,
  input wire cfgDemand,
  input wire cfgSrcSync,
  input wire cfgSrcIncr,
  input wire cfgDstIncr,
  input wire [31:0] cfgSrcAddr,
  input wire [31:0] cfgDstAddr,
  input wire [31:0] cfgCount,
  output reg busy,
  output reg done,
  output reg cfgError,
  input wire xfer_request_n,
  output reg xfer_ack_n,
  output reg busReq,
  output reg busWrite,
  output reg [31:0] busAddr,
  output reg [1:0] busSize,
  output wire [127:0] busWdata,
  output wire busDataDrive,
  input wire [127:0] busRdata,
  input wire busDone
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_PICK = 7'h02;
  localparam [6:0] S_LOAD = 7'h04;
  localparam [6:0] S_PUSH = 7'h08;
  localparam [6:0] S_POP = 7'h10;
  localparam [6:0] S_STORE = 7'h20;
  localparam [6:0] S_FLY = 7'h40;

  reg [6:0] state;
  reg [1:0] srcLen;
  reg [1:0] dstLen;
  reg flyBy;
  reg demand;
  reg srcSync;
  reg srcIncr;
  reg dstIncr;
  reg [31:0] srcAddr;
  reg [31:0] dstAddr;
  reg [31:0] srcLeft;
  reg [31:0] dstLeft;
  reg [127:0] shiftReg;
  reg [4:0] unit;
  reg [4:0] idx;
  reg acked;
  reg serviced;
  wire reqSyncN;
  wire reqLive;
  wire fifoInReady;
  wire fifoOutValid;
  wire [7:0] fifoOutData;
  wire [5:0] fifoLevel;
  wire [5:0] fifoSpace;
  wire [4:0] srcSz;
  wire [4:0] dstSz;
  wire [4:0] flySz;
  wire [31:0] flyAddr;
  wire startBad;

  // Largest request that fits the length, the address alignment and the bytes left; quad length always gives 16 bytes.
  function [4:0] reqBytes;
    input [31:0] addr;
    input [1:0] len;
    input [31:0] left;
    begin
      if (len == `DFRLA_LEN_QUAD)
        reqBytes = `DFRLA_BYTES_QUAD;
      else if (len == `DFRLA_LEN_WORD && addr[1:0] == 2'h0 && left >= 32'h00000004)
        reqBytes = `DFRLA_BYTES_WORD;
      else if (len != `DFRLA_LEN_BYTE && addr[0] == 1'b0 && left >= 32'h00000002)
        reqBytes = `DFRLA_BYTES_SHORT;
      else
        reqBytes = `DFRLA_BYTES_BYTE;
    end
  endfunction

  // Bus size code from a request length in bytes.
  function [1:0] sizeCode;
    input [4:0] nBytes;
    begin
      case (nBytes)
        `DFRLA_BYTES_QUAD: sizeCode = `DFRLA_LEN_QUAD;
        `DFRLA_BYTES_WORD: sizeCode = `DFRLA_LEN_WORD;
        `DFRLA_BYTES_SHORT: sizeCode = `DFRLA_LEN_SHORT;
        default: sizeCode = `DFRLA_LEN_BYTE;
      endcase
    end
  endfunction

  // Fly-by addresses must both lie outside the on-chip data RAM.
  function inRam;
    input [31:0] addr;
    begin
      inRam = (addr < INT_RAM_TOP);
    end
  endfunction

  dfrla_pin_sync u_reqSync (
    .clk(clk),
    .rst(rst),
    .pinN(xfer_request_n),
    .syncN(reqSyncN)
  );

  dfrla_fifo #(
    .WIDTH(`DFRLA_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(state == S_PUSH),
    .inReady(fifoInReady),
    .inData(shiftReg[7:0]),
    .outValid(fifoOutValid),
    .outReady(state == S_POP),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  // A request counts once; it must fall before the next one is served.
  assign reqLive = !reqSyncN && !serviced && demand;
  assign fifoSpace = FIFO_DEPTH[5:0] - fifoLevel;
  assign srcSz = reqBytes(srcAddr, srcLen, srcLeft);
  assign dstSz = reqBytes(dstAddr, dstLen, dstLeft);
  assign flyAddr = srcSync ? dstAddr : srcAddr;
  assign flySz = reqBytes(flyAddr, srcLen, dstLeft);
  assign busWdata = shiftReg;
  assign busDataDrive = busReq && busWrite && !flyBy;

  // Refused set-ups: mixed quad, unaligned quad, unequal fly-by, fly-by into RAM.
  assign startBad = ((cfgSrcLen == `DFRLA_LEN_QUAD) != (cfgDstLen == `DFRLA_LEN_QUAD))
    || (cfgSrcLen == `DFRLA_LEN_QUAD && (cfgSrcAddr[3:0] != 4'h0 || cfgDstAddr[3:0] != 4'h0))
    || (cfgFlyBy && cfgSrcLen != cfgDstLen)
    || (cfgFlyBy && (inRam(cfgSrcAddr) || inRam(cfgDstAddr)));

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      srcLen <= `DFRLA_LEN_BYTE;
      dstLen <= `DFRLA_LEN_BYTE;
      flyBy <= 1'b0;
      demand <= 1'b0;
      srcSync <= 1'b0;
      srcIncr <= 1'b0;
      dstIncr <= 1'b0;
      srcAddr <= 32'h00000000;
      dstAddr <= 32'h00000000;
      srcLeft <= 32'h00000000;
      dstLeft <= 32'h00000000;
      shiftReg <= 128'h0;
      unit <= 5'h00;
      idx <= 5'h00;
      acked <= 1'b0;
      serviced <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      cfgError <= 1'b0;
      xfer_ack_n <= `DFRLA_PIN_IDLE;
      busReq <= 1'b0;
      busWrite <= 1'b0;
      busAddr <= 32'h00000000;
      busSize <= `DFRLA_LEN_BYTE;
    end
    else
    begin
      done <= 1'b0;
      cfgError <= 1'b0;
      if (reqSyncN)
        serviced <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            srcLen <= cfgSrcLen;
            dstLen <= cfgDstLen;
            flyBy <= cfgFlyBy;
            demand <= cfgDemand;
            srcSync <= cfgSrcSync;
            srcIncr <= cfgSrcIncr;
            dstIncr <= cfgDstIncr;
            srcAddr <= cfgSrcAddr;
            dstAddr <= cfgDstAddr;
            srcLeft <= cfgCount;
            dstLeft <= cfgCount;
            if (startBad)
              cfgError <= 1'b1;
            else if (cfgCount == 32'h00000000)
              done <= 1'b1;
            else
            begin
              busy <= 1'b1;
              state <= S_PICK;
            end
          end
        end
        S_PICK:
        begin
          if (dstLeft == 32'h00000000)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= S_IDLE;
          end
          else if (flyBy)
          begin
            if (!demand || reqLive)
            begin
              busReq <= 1'b1;
              busWrite <= srcSync;
              busAddr <= flyAddr;
              busSize <= sizeCode(flySz);
              unit <= flySz;
              acked <= 1'b1;
              xfer_ack_n <= 1'b0;
              state <= S_FLY;
            end
          end
          else if ({1'b0, fifoLevel} >= {1'b0, dstSz} && (!demand || srcSync || reqLive))
          begin
            shiftReg <= 128'h0;
            unit <= dstSz;
            idx <= 5'h00;
            acked <= demand && !srcSync;
            state <= S_POP;
          end
          else if (srcLeft != 32'h00000000 && {1'b0, fifoSpace} >= {1'b0, srcSz}
            && (!demand || !srcSync || reqLive))
          begin
            busReq <= 1'b1;
            busWrite <= 1'b0;
            busAddr <= srcAddr;
            busSize <= sizeCode(srcSz);
            unit <= srcSz;
            acked <= demand && srcSync;
            xfer_ack_n <= !(demand && srcSync);
            state <= S_LOAD;
          end
        end
        S_LOAD:
        begin
          if (busDone)
          begin
            busReq <= 1'b0;
            xfer_ack_n <= `DFRLA_PIN_IDLE;
            shiftReg <= busRdata;
            idx <= 5'h00;
            if (acked)
              serviced <= 1'b1;
            if (srcIncr)
              srcAddr <= srcAddr + {27'h0, unit};
            srcLeft <= srcLeft - {27'h0, unit};
            state <= S_PUSH;
          end
        end
        S_PUSH:
        begin
          if (fifoInReady)
          begin
            shiftReg <= {8'h00, shiftReg[127:8]};
            idx <= idx + 5'h01;
            if (idx == unit - 5'h01)
              state <= S_PICK;
          end
        end
        S_POP:
        begin
          if (fifoOutValid)
          begin
            shiftReg[idx*8 +: 8] <= fifoOutData;
            idx <= idx + 5'h01;
            if (idx == unit - 5'h01)
            begin
              busReq <= 1'b1;
              busWrite <= 1'b1;
              busAddr <= dstAddr;
              busSize <= sizeCode(unit);
              xfer_ack_n <= !acked;
              state <= S_STORE;
            end
          end
        end
        S_STORE:
        begin
          if (busDone)
          begin
            busReq <= 1'b0;
            busWrite <= 1'b0;
            xfer_ack_n <= `DFRLA_PIN_IDLE;
            if (acked)
              serviced <= 1'b1;
            if (dstIncr)
              dstAddr <= dstAddr + {27'h0, unit};
            dstLeft <= dstLeft - {27'h0, unit};
            state <= S_PICK;
          end
        end
        S_FLY:
        begin
          if (busDone)
          begin
            busReq <= 1'b0;
            busWrite <= 1'b0;
            xfer_ack_n <= `DFRLA_PIN_IDLE;
            if (demand)
              serviced <= 1'b1;
            if (srcSync && dstIncr)
              dstAddr <= dstAddr + {27'h0, unit};
            if (!srcSync && srcIncr)
              srcAddr <= srcAddr + {27'h0, unit};
            srcLeft <= srcLeft - {27'h0, unit};
            dstLeft <= dstLeft - {27'h0, unit};
            state <= S_PICK;
          end
        end
        default:
        begin
          busReq <= 1'b0;
          xfer_ack_n <= `DFRLA_PIN_IDLE;
          busy <= 1'b0;
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // dfrla_engine

// file: dfrla_map.vh
// Purpose: Shared constants of the fly-by and request length transfer engine.
// Assumes: Included by bare name from every design file of the engine.
// Notes: Definitions only.
`ifndef DFRLA_MAP_VH
`define DFRLA_MAP_VH

// Request length codes, also used as the bus request size code.
`define DFRLA_LEN_BYTE 2'h0
`define DFRLA_LEN_SHORT 2'h1
`define DFRLA_LEN_WORD 2'h2
`define DFRLA_LEN_QUAD 2'h3

// Request length in bytes.
`define DFRLA_BYTES_BYTE 5'h01
`define DFRLA_BYTES_SHORT 5'h02
`define DFRLA_BYTES_WORD 5'h04
`define DFRLA_BYTES_QUAD 5'h10

// Byte buffer between load and store sides.
`define DFRLA_FIFO_WIDTH 8
`define DFRLA_FIFO_DEPTH 32

// First address above the on-chip data RAM.
`define DFRLA_INT_RAM_TOP 32'h00000400

// Reset value of the active-low pins.
`define DFRLA_PIN_IDLE 1'h1

`endif

// file: dfrla_pin_sync.v
// Purpose: Brings the active-low transfer request pin into the clock domain.
// Assumes: The pin is asynchronous to clk.
// Notes: The output changes only once the second and third stages agree.
`timescale 1ns/100ps
`include "dfrla_map.vh"

module dfrla_pin_sync (
  input wire clk,
  input wire rst,
  input wire pinN,
  output reg syncN
);

  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= `DFRLA_PIN_IDLE;
      stage2 <= `DFRLA_PIN_IDLE;
      stage3 <= `DFRLA_PIN_IDLE;
      syncN <= `DFRLA_PIN_IDLE;
    end
    else
    begin
      stage1 <= pinN;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
      begin
        syncN <= stage3;
      end
    end
  end

endmodule // dfrla_pin_sync

// file: dfrla_fifo.v
// Purpose: Byte buffer that packs and unpacks between source and destination.
// Assumes: DEPTH is a power of two.
// Notes: Valid and ready on both sides; level reports the words held.
`timescale 1ns/100ps
`include "dfrla_map.vh"

module dfrla_fifo #(
  parameter WIDTH = `DFRLA_FIFO_WIDTH,
  parameter DEPTH = `DFRLA_FIFO_DEPTH,
  parameter AW = 5
) (
  input wire clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output reg [AW:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  wire doPush;
  wire doPop;

  assign inReady = (level != DEPTH[AW:0]);
  assign outValid = (level != {(AW+1){1'b0}});
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always @(posedge clk)
  begin
    if (doPush)
    begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (doPush && !doPop)
      begin
        level <= level + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        level <= level - 1'b1;
      end
    end
  end

endmodule // dfrla_fifo

// file: dfrla_engine_sva.sv
// Purpose: Assertions on the transfer engine's bus and acknowledge ports.
// Assumes: Configuration inputs stay steady while busy is high.
// Notes: Bound to every engine instance.
`timescale 1ns/100ps
`include "dfrla_map.vh"
module dfrla_engine_sva #(
  parameter INT_RAM_TOP = `DFRLA_INT_RAM_TOP,
  parameter FIFO_DEPTH = `DFRLA_FIFO_DEPTH
) (
  input wire clk,
  input wire rst,
  input wire start,
  input wire busy,
  input wire done,
  input wire cfgError,
  input wire [1:0] cfgSrcLen,
  input wire cfgFlyBy,
  input wire cfgDemand,
  input wire cfgSrcSync,
  input wire xfer_ack_n,
  input wire busReq,
  input wire busWrite,
  input wire [31:0] busAddr,
  input wire [1:0] busSize,
  input wire busDataDrive,
  input wire busDone
);
  wire flyReq = busy && cfgFlyBy && busReq;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence reqHold;
    busReq && !busDone;
  endsequence
  sequence reqEnd;
    busReq && busDone;
  endsequence
  hold_req_a: assert property (reqHold |=> busReq && $stable(busAddr) && $stable(busSize)
    && $stable(xfer_ack_n)) else $error("request changed before done");
  release_a: assert property (reqEnd |=> !busReq && xfer_ack_n)
    else $error("request not released after done");
  ack_own_a: assert property (!xfer_ack_n |-> busReq)
    else $error("acknowledge outside a request");
  fly_float_a: assert property (flyReq |-> !busDataDrive)
    else $error("data bus driven during fly-by");
  fly_dir_a: assert property (flyReq |-> busWrite == cfgSrcSync && busSize == cfgSrcLen)
    else $error("fly-by direction or size wrong");
  fly_ext_a: assert property (flyReq |-> busAddr >= INT_RAM_TOP)
    else $error("fly-by reached internal RAM");
  block_ack_a: assert property (busy && !cfgDemand && !cfgFlyBy |-> xfer_ack_n)
    else $error("acknowledge in block mode");
  quad_align_a: assert property (busReq && busSize == `DFRLA_LEN_QUAD |-> busAddr[3:0] == 4'h0)
    else $error("quad request unaligned");
  word_align_a: assert property (busReq && busSize == `DFRLA_LEN_WORD |-> busAddr[1:0] == 2'h0)
    else $error("word request unaligned");
  start_ans_a: assert property (start && !busy |=> busy || done || cfgError)
    else $error("start not answered");
endmodule // dfrla_engine_sva
bind dfrla_engine dfrla_engine_sva #(.INT_RAM_TOP(INT_RAM_TOP), .FIFO_DEPTH(FIFO_DEPTH)) chk (.clk, .rst,
  .start, .busy, .done, .cfgError, .cfgSrcLen, .cfgFlyBy, .cfgDemand, .cfgSrcSync, .xfer_ack_n, .busReq,
  .busWrite, .busAddr, .busSize, .busDataDrive, .busDone);

// file: dfrla_bus_model.sv
// Purpose: Bus controller and memory answering the engine's requests.
// Assumes: Memory byte at an address is its low byte xor 8'ha5.
// Notes: Answers after 0 to 3 idle cycles; read lines toggle when released.
`timescale 1ns/100ps
module dfrla_bus_model (
  input wire clk,
  input wire rst,
  input wire busReq,
  input wire [31:0] busAddr,
  output reg [127:0] busRdata,
  output reg busDone
);
  integer seed = 32'hc9cd;
  integer k;
  reg pend;
  reg [31:0] dly;
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      busDone <= 1'b0;
      pend <= 1'b0;
      dly <= 32'h0;
      busRdata <= 128'h0;
    end
    else
    begin
      busDone <= 1'b0;
      busRdata <= ~busRdata;
      if (busReq && !pend && !busDone)
      begin
        pend <= 1'b1;
        dly <= $random(seed) & 32'h3;
      end
      else if (pend && dly != 32'h0)
        dly <= dly - 32'h1;
      else if (pend)
      begin
        pend <= 1'b0;
        busDone <= 1'b1;
        for (k = 0; k < 16; k = k + 1)
          busRdata[8*k +: 8] <= (busAddr[7:0] + k[7:0]) ^ 8'ha5;
      end
    end
endmodule // dfrla_bus_model

// file: tb_dma_flyby_request_length_align.sv
// Purpose: Self-checking bench of the transfer engine.
// Assumes: Request lists are predicted per side and compared in order.
// Notes: Pin pulses wait for the acknowledge before rearming.
`timescale 1ns/100ps
`include "dfrla_map.vh"
module tb_dma_flyby_request_length_align;
  reg clk = 0, rst = 1, start = 0, cfgFlyBy = 0, cfgDemand = 0, cfgSrcSync = 0, xfer_request_n = 1;
  reg cfgSrcIncr = 1, cfgDstIncr = 1;
  reg [1:0] cfgSrcLen = 0, cfgDstLen = 0;
  reg [31:0] cfgSrcAddr = 0, cfgDstAddr = 0, cfgCount = 0;
  wire busy, done, cfgError, xfer_ack_n, busReq, busWrite, busDataDrive, busDone;
  wire [31:0] busAddr;
  wire [1:0] busSize;
  wire [127:0] busWdata, busRdata;
  integer error_cnt = 0, cmp_count = 0, seed = 32'hc9cd, ldCnt = 0, j;
  reg doneSeen = 0, errSeen = 0;
  reg [34:0] ldQ[$], stQ[$], e, g;
  reg [7:0] sb[$];
  reg [127:0] w, m;
  always #12.5 clk = ~clk;
  dfrla_engine DUT (.clk, .rst, .start, .cfgSrcLen, .cfgDstLen, .cfgFlyBy, .cfgDemand, .cfgSrcSync,
    .cfgSrcIncr, .cfgDstIncr, .cfgSrcAddr, .cfgDstAddr, .cfgCount, .busy, .done, .cfgError,
    .xfer_request_n, .xfer_ack_n, .busReq, .busWrite, .busAddr, .busSize, .busWdata, .busDataDrive,
    .busRdata, .busDone);
  dfrla_bus_model bus (.clk, .rst, .busReq, .busAddr, .busRdata, .busDone);
  task chk(input [127:0] seen, input [127:0] exp, input string nm);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Predicts one side's requests: widest aligned unit within length and bytes left; quad length is always 16 bytes.
  task plan(input [31:0] a, input [31:0] n, input [1:0] len, input ack, input wr);
    reg [4:0] u;
    integer k;
    begin
      while (n > 0)
      begin
        u = (len == `DFRLA_LEN_QUAD) ? 5'h10 : 5'h04;
        while (u != 5'h10 && (u > (5'h01 << len) || a % u != 0 || u > n))
          u = u >> 1;
        e = {ack, u[4] ? 2'h3 : u[2] ? 2'h2 : {1'b0, u[1]}, a};
        if (wr)
          stQ.push_back(e);
        else
          ldQ.push_back(e);
        for (k = 0; k < u && !wr && !cfgFlyBy; k++)
          sb.push_back((a[7:0] + k[7:0]) ^ 8'ha5);
        if (wr ? cfgDstIncr : cfgSrcIncr)
          a = a + u;
        n = n - u;
      end
    end
  endtask
  always @(posedge clk)
  begin
    if (done)
      doneSeen <= 1;
    if (cfgError)
      errSeen <= 1;
    if (!rst && busReq && busDone)
    begin
      if (!busWrite)
        ldCnt = ldCnt + 1;
      if ((busWrite ? stQ.size() : ldQ.size()) == 0)
        chk(1, 0, "extra request");
      else
      begin
        g = busWrite ? stQ.pop_front() : ldQ.pop_front();
        chk({xfer_ack_n, busSize, busAddr}, {~g[34], g[33:0]}, "request");
        chk(busDataDrive, busWrite && !cfgFlyBy, "data drive");
        if (busWrite && !cfgFlyBy)
        begin
          w = 0;
          m = 0;
          for (j = 0; j < (busSize == 2'h3 ? 16 : 1 << busSize); j++)
          begin
            if (sb.size() > 0)
              w[8*j +: 8] = sb.pop_front();
            m[8*j +: 8] = 8'hff;
          end
          chk(busWdata & m, w, "store data");
        end
      end
    end
  end
  task pulse;
    integer k;
    begin
      xfer_request_n <= 1'b0;
      for (k = 0; k < 40 && xfer_ack_n && !doneSeen; k++)
        @(posedge clk);
      for (k = 0; k < 40 && !xfer_ack_n; k++)
        @(posedge clk);
      xfer_request_n <= 1'b1;
      repeat (6) @(posedge clk);
    end
  endtask
  // Mode bits are fly-by, demand, source synchronised.
  task run(input [1:0] sl, input [1:0] dl, input [2:0] md, input [31:0] sa, input [31:0] da, input [31:0] n,
    input bad);
    integer k;
    begin
      @(posedge clk);
      xfer_request_n <= 1'b1;
      repeat (5) @(posedge clk);
      {cfgFlyBy, cfgDemand, cfgSrcSync} <= md;
      {cfgSrcLen, cfgDstLen, cfgSrcAddr, cfgDstAddr, cfgCount} <= {sl, dl, sa, da, n};
      @(posedge clk);
      if (!bad && (!md[2] || !md[0]))
        plan(sa, n, sl, md[2] | md[1] & md[0], 0);
      if (!bad && (!md[2] || md[0]))
        plan(da, n, md[2] ? sl : dl, md[2] | md[1] & !md[0], 1);
      doneSeen = 0;
      errSeen = 0;
      ldCnt = 0;
      start <= 1;
      @(posedge clk);
      start <= 0;
      xfer_request_n <= md[1];
      if (md == 3'b010)
      begin
        repeat (300) @(posedge clk);
        chk(ldCnt, `DFRLA_FIFO_DEPTH, "loads before stall");
      end
      for (k = 0; k < 600 && !doneSeen && !errSeen; k++)
        if (md[1])
          pulse;
        else
          @(posedge clk);
      if (k == 600)
      begin
        chk(0, 1, "timeout");
        stop_test;
      end
      else
      begin
        chk(errSeen, bad, "refused");
        chk(ldQ.size() + stQ.size(), 0, "missing requests");
      end
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 0;
    cfgDstIncr <= 1'b0;
    run(`DFRLA_LEN_BYTE, `DFRLA_LEN_WORD, 3'b000, 32'h2000, 32'h3000, 8, 0);
    cfgDstIncr <= 1'b1;
    run(`DFRLA_LEN_WORD, `DFRLA_LEN_SHORT, 3'b000, 32'h2000 + ($random(seed) & 7), 32'h3003,
      5 + ($random(seed) & 15), 0);
    run(`DFRLA_LEN_QUAD, `DFRLA_LEN_QUAD, 3'b000, 32'h4000, 32'h5000, 32, 0);
    run(`DFRLA_LEN_QUAD, `DFRLA_LEN_WORD, 3'b000, 32'h4000, 32'h5000, 32, 1);
    run(`DFRLA_LEN_QUAD, `DFRLA_LEN_QUAD, 3'b000, 32'h4008, 32'h5000, 32, 1);
    run(`DFRLA_LEN_WORD, `DFRLA_LEN_WORD, 3'b111, 32'h6000, 32'h7000, 12, 0);
    run(`DFRLA_LEN_SHORT, `DFRLA_LEN_SHORT, 3'b110, 32'h8000, 32'h9000, 6, 0);
    cfgSrcIncr <= 1'b0;
    run(`DFRLA_LEN_WORD, `DFRLA_LEN_WORD, 3'b100, 32'h6000, 32'h7000, 8, 0);
    cfgSrcIncr <= 1'b1;
    run(`DFRLA_LEN_WORD, `DFRLA_LEN_WORD, 3'b111, 32'h6000, 32'h0100, 4, 1);
    run(`DFRLA_LEN_BYTE, `DFRLA_LEN_WORD, 3'b111, 32'h6000, 32'h7000, 4, 1);
    run(`DFRLA_LEN_BYTE, `DFRLA_LEN_BYTE, 3'b010, 32'h2000, 32'h3000, 40, 0);
    stop_test;
  end
endmodule // tb_dma_flyby_request_length_align
